/* hdl/dtor_out_select.sv */
// Output select: override value, ramp injection and output enable for the sample path
`timescale 1ns/1ps
module dtor_out_select
    import dtor_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic input_data_clock_en,
    input wire logic [15:0] sample_in,
    input wire logic signed_format,
    input wire logic software_tx_enable,
    input wire logic transmit_enable_pin,
    input wire logic ramp_ena,
    input wire logic override_ena,
    input wire logic [15:0] override_value,
    output logic [15:0] fifo_entry_data,
    output logic [15:0] inphase_channel,
    output logic [15:0] quadrature_channel,
    output logic output_enable
);
    logic [15:0] ramp;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ramp <= 16'h0000;
        end else if (input_data_clock_en && ramp_ena) begin
            ramp <= ramp + 16'h0001;
        end
    end

    // Ramp replaces the sample at the FIFO entry
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fifo_entry_data <= 16'h0000;
        end else if (input_data_clock_en) begin
            fifo_entry_data <= ramp_ena ? ramp : sample_in;
        end
    end

    // Override only latched on an input data clock tick; a stopped clock freezes both channels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inphase_channel <= 16'h0000;
            quadrature_channel <= 16'h0000;
        end else if (input_data_clock_en) begin
            if (override_ena) begin
                // Two's-complement input is flipped to offset binary like ordinary samples
                inphase_channel <= override_value ^ {signed_format, 15'h0000};
                quadrature_channel <= override_value ^ {signed_format, 15'h0000};
            end else begin
                inphase_channel <= fifo_entry_data ^ {signed_format, 15'h0000};
                quadrature_channel <= fifo_entry_data ^ {signed_format, 15'h0000};
            end
        end
    end

    // Transmit enables are ignored under override
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= override_ena | (software_tx_enable & transmit_enable_pin);
        end
    end
endmodule // dtor_out_select

/* hdl/dtor_pkg.sv */
// Package: register map, reset values and field positions for the test override bank
package dtor_pkg;
    localparam int dtor_data_w = 32;
    localparam int dtor_addr_w = 12;
    localparam int dtor_word_w = 16;

    // Register indices; byte address is four times the index
    localparam logic [7:0] dtor_idx_word3 = 8'h28;
    localparam logic [7:0] dtor_idx_word4 = 8'h29;
    localparam logic [7:0] dtor_idx_word5 = 8'h2a;
    localparam logic [7:0] dtor_idx_word6 = 8'h2b;
    localparam logic [7:0] dtor_idx_word7 = 8'h2c;
    localparam logic [7:0] dtor_idx_control = 8'h2d;
    localparam logic [7:0] dtor_idx_itrim = 8'h2e;
    localparam logic [7:0] dtor_idx_qtrim = 8'h2f;
    localparam logic [7:0] dtor_idx_override = 8'h30;
    localparam logic [7:0] dtor_idx_chipid = 8'h7f;
    localparam int dtor_num_words = 5;

    localparam logic [15:0] dtor_rst_word3 = 16'h4545;
    localparam logic [15:0] dtor_rst_word4 = 16'h1a1a;
    localparam logic [15:0] dtor_rst_word5 = 16'h1616;
    localparam logic [15:0] dtor_rst_word6 = 16'haaaa;
    localparam logic [15:0] dtor_rst_word7 = 16'hc6c6;
    localparam logic [15:0] dtor_rst_control = 16'h0004;
    localparam logic [15:0] dtor_rst_itrim = 16'h0000;
    localparam logic [15:0] dtor_rst_qtrim = 16'h0000;
    localparam logic [15:0] dtor_rst_override = 16'h0000;

    // Control fields
    localparam int dtor_bit_strobe_sel = 14;
    localparam int dtor_bit_ramp_ena = 13;
    localparam int dtor_bit_override_ena = 0;
    // Writable mask: reserved fields keep their defaults
    localparam logic [15:0] dtor_ctrl_wmask = 16'h6001;
    localparam logic [15:0] dtor_itrim_wmask = 16'h00ff;
    localparam logic [15:0] dtor_qtrim_wmask = 16'hff00;

    // Identification fields; the values are arbitrary
    localparam logic [5:0] dtor_id_upper = 6'h00;
    localparam logic [1:0] dtor_device_id = 2'h2;
    localparam logic [2:0] dtor_silicon_rev = 3'h1;

    localparam logic [1:0] dtor_resp_okay = 2'h0;
    localparam logic [1:0] dtor_resp_slverr = 2'h2;
endpackage

/* hdl/dtor_regs.sv */
// Test override register bank with AXI4-Lite slave and datapath controls
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module dtor_regs
    import dtor_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [dtor_pkg::dtor_addr_w-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dtor_pkg::dtor_data_w-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dtor_pkg::dtor_addr_w-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dtor_pkg::dtor_data_w-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic input_data_clock_en,
    input wire logic [15:0] sample_in,
    input wire logic signed_format,
    input wire logic software_tx_enable,
    input wire logic transmit_enable_pin,
    input wire logic external_strobe,
    input wire logic internal_strobe,
    output logic divider_strobe,
    output logic [15:0] test_word_three,
    output logic [15:0] test_word_four,
    output logic [15:0] test_word_five,
    output logic [15:0] test_word_six,
    output logic [15:0] test_word_seven,
    output logic [7:0] inphase_delay,
    output logic [7:0] quadrature_delay,
    output logic [15:0] fifo_entry_data,
    output logic [15:0] inphase_channel,
    output logic [15:0] quadrature_channel,
    output logic output_enable
);
    logic rst_meta;
    logic rst_n;
    logic [15:0] words [dtor_num_words];
    logic [15:0] test_override_control;
    logic [15:0] inphase_delay_trim;
    logic [15:0] quadrature_delay_trim;
    logic [15:0] output_override_value;
    logic [dtor_addr_w-1:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [7:0] w_idx;
    logic [7:0] r_idx;
    logic w_hit;
    logic [15:0] next_rdata;
    logic next_rhit;

    // Reset released through two flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Write channels taken independently, in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held;
    assign w_idx = aw_addr[9:2];
    assign w_hit = (aw_addr[1:0] == 2'h0) && (aw_addr[dtor_addr_w-1:10] == '0) &&
        ((w_idx >= dtor_idx_word3 && w_idx <= dtor_idx_override) || w_idx == dtor_idx_chipid);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dtor_resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? dtor_resp_okay : dtor_resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [15:0] dtor_merge(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lanes) | (data[15:0] & lanes);
    endfunction

    // Pattern words three to seven
    generate
        for (genvar i = 0; i < dtor_num_words; i++) begin : g_word
            localparam logic [15:0] rst_val = (i == 0) ? dtor_rst_word3 : (i == 1) ? dtor_rst_word4 :
                (i == 2) ? dtor_rst_word5 : (i == 3) ? dtor_rst_word6 : dtor_rst_word7;
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    words[i] <= rst_val;
                end else if (do_write && w_hit && w_idx == dtor_idx_word3 + 8'(i)) begin
                    words[i] <= dtor_merge(words[i], w_data, w_strb, 16'hffff);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_override_control <= dtor_rst_control;
            inphase_delay_trim <= dtor_rst_itrim;
            quadrature_delay_trim <= dtor_rst_qtrim;
            output_override_value <= dtor_rst_override;
        end else if (do_write && w_hit) begin
            // Reserved bits are masked so they always hold their defaults
            if (w_idx == dtor_idx_control) begin
                test_override_control <= dtor_merge(test_override_control, w_data, w_strb,
                                                    dtor_ctrl_wmask);
            end
            if (w_idx == dtor_idx_itrim) begin
                inphase_delay_trim <= dtor_merge(inphase_delay_trim, w_data, w_strb, dtor_itrim_wmask);
            end
            if (w_idx == dtor_idx_qtrim) begin
                quadrature_delay_trim <= dtor_merge(quadrature_delay_trim, w_data, w_strb, dtor_qtrim_wmask);
            end
            if (w_idx == dtor_idx_override) begin
                output_override_value <= dtor_merge(output_override_value, w_data, w_strb, 16'hffff);
            end
        end
    end

    // Read path: one cycle latency, one outstanding read
    assign s_axi_arready = !s_axi_rvalid;
    assign r_idx = s_axi_araddr[9:2];

    always_comb begin
        next_rhit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[dtor_addr_w-1:10] == '0);
        next_rdata = 16'h0000;
        if (r_idx >= dtor_idx_word3 && r_idx <= dtor_idx_word7) begin
            next_rdata = words[3'(r_idx - dtor_idx_word3)];
        end else if (r_idx == dtor_idx_control) begin
            next_rdata = test_override_control;
        end else if (r_idx == dtor_idx_itrim) begin
            next_rdata = inphase_delay_trim;
        end else if (r_idx == dtor_idx_qtrim) begin
            next_rdata = quadrature_delay_trim;
        end else if (r_idx == dtor_idx_override) begin
            next_rdata = output_override_value;
        end else if (r_idx == dtor_idx_chipid) begin
            // Fixed fields, no storage behind them
            next_rdata = {dtor_id_upper, 5'h00, dtor_device_id, dtor_silicon_rev};
        end else begin
            next_rhit = 1'b0;
        end
        if (!next_rhit) begin
            next_rdata = 16'h0000;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= dtor_resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, next_rdata};
            s_axi_rresp <= next_rhit ? dtor_resp_okay : dtor_resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Strobe mux is combinational so the routed strobe adds no cycle of delay
    assign divider_strobe = test_override_control[dtor_bit_strobe_sel] ? external_strobe
                                                                       : internal_strobe;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_word_three <= dtor_rst_word3;
            test_word_four <= dtor_rst_word4;
            test_word_five <= dtor_rst_word5;
            test_word_six <= dtor_rst_word6;
            test_word_seven <= dtor_rst_word7;
            inphase_delay <= 8'h00;
            quadrature_delay <= 8'h00;
        end else begin
            test_word_three <= words[0];
            test_word_four <= words[1];
            test_word_five <= words[2];
            test_word_six <= words[3];
            test_word_seven <= words[4];
            inphase_delay <= inphase_delay_trim[7:0];
            quadrature_delay <= quadrature_delay_trim[15:8];
        end
    end

    dtor_out_select u_out_select (
        .clock(clock),
        .rst_n(rst_n),
        .input_data_clock_en(input_data_clock_en),
        .sample_in(sample_in),
        .signed_format(signed_format),
        .software_tx_enable(software_tx_enable),
        .transmit_enable_pin(transmit_enable_pin),
        .ramp_ena(test_override_control[dtor_bit_ramp_ena]),
        .override_ena(test_override_control[dtor_bit_override_ena]),
        .override_value(output_override_value),
        .fifo_entry_data(fifo_entry_data),
        .inphase_channel(inphase_channel),
        .quadrature_channel(quadrature_channel),
        .output_enable(output_enable)
    );
endmodule // dtor_regs

/* verif/dtor_monitor.sv */
// Port checker for the test override register bank
`timescale 1ns/1ps
module dtor_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [dtor_pkg::dtor_data_w-1:0] s_axi_rdata,
    input wire logic software_tx_enable,
    input wire logic transmit_enable_pin,
    input wire logic input_data_clock_en,
    input wire logic [15:0] inphase_channel,
    input wire logic [15:0] quadrature_channel,
    input wire logic output_enable
);
    logic [2:0] live;

    // Internal reset lags the pin by two edges, so wait it out
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) live <= 3'h0;
        else live <= {live[1:0], 1'h1};
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!live[2]);

    chk_write_ack: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    chk_write_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while answer pending");
    chk_resp_drop: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response not released");
    chk_read_ack: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
    chk_read_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read half not zero");
    chk_enable_both: assert property (
        software_tx_enable && transmit_enable_pin |=> output_enable) else $error("output enable missing");
    chk_tick_freeze: assert property (
        !input_data_clock_en |=> $stable(inphase_channel) && $stable(quadrature_channel))
        else $error("channel moved without data clock");
    chk_channel_pair: assert property (
        inphase_channel == quadrature_channel) else $error("channels differ");

    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_tick: cover property (input_data_clock_en ##1 !input_data_clock_en);
endmodule // dtor_monitor

bind dtor_regs dtor_monitor u_dtor_monitor (.clock, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .software_tx_enable, .transmit_enable_pin, .input_data_clock_en, .inphase_channel,
    .quadrature_channel, .output_enable);

/* verif/dtor_regs_tb.sv */
// Self-checking bench for the test override register bank
`timescale 1ns/1ps
module dtor_regs_tb;
    import dtor_pkg::*;
    localparam logic [15:0] dflt [5] = '{16'h4545, 16'h1a1a, 16'h1616, 16'haaaa, 16'hc6c6};
    logic clock = 1'h0, arst_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic input_data_clock_en = 1'h0, signed_format = 1'h0, software_tx_enable = 1'h0, transmit_enable_pin = 1'h0;
    logic external_strobe = 1'h0, internal_strobe = 1'h0, divider_strobe, output_enable;
    logic [15:0] sample_in = 16'h0, test_word_three, test_word_four, test_word_five, test_word_six, test_word_seven;
    logic [7:0] inphase_delay, quadrature_delay;
    logic [15:0] fifo_entry_data, inphase_channel, quadrature_channel;
    logic [15:0] tw [5];
    int fails = 0, compares = 0;

    dtor_regs u_dtor_regs (.clock, .arst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .input_data_clock_en, .sample_in, .signed_format, .software_tx_enable, .transmit_enable_pin,
        .external_strobe, .internal_strobe, .divider_strobe, .test_word_three, .test_word_four, .test_word_five,
        .test_word_six, .test_word_seven, .inphase_delay, .quadrature_delay, .fifo_entry_data, .inphase_channel,
        .quadrature_channel, .output_enable);

    always_comb tw = '{test_word_three, test_word_four, test_word_five, test_word_six, test_word_seven};
    initial forever #4 clock = ~clock;

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Address and data offered together; each released once its own ready is seen
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'h0;
        cmp("bvalid", 32'h1, {31'h0, s_axi_bvalid});
        cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [15:0] ed, input logic [1:0] er, input string what);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'h0;
        cmp("rvalid", 32'h1, {31'h0, s_axi_rvalid});
        cmp(what, {16'h0, ed}, s_axi_rdata);
        cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic tick();
        @(posedge clock);
        input_data_clock_en <= 1'h1;
        @(posedge clock);
        input_data_clock_en <= 1'h0;
        @(posedge clock);
    endtask

    // All writes first, so an address alias shows up on read-back
    task automatic t_words();
        for (int i = 0; i < 5; i++) begin
            // Words kept in sequence order; word zero alignment is up to the sender
            rd(8'h28 + 8'(i), dflt[i], 2'h0, "word default");
            wr(8'h28 + 8'(i), ~dflt[i], 2'h0);
        end
        for (int i = 0; i < 5; i++) begin
            rd(8'h28 + 8'(i), ~dflt[i], 2'h0, "word back");
            cmp("word port", {16'h0, ~dflt[i]}, {16'h0, tw[i]});
        end
    endtask

    task automatic t_fields();
        rd(8'h2d, 16'h0004, 2'h0, "control default");
        rd(8'h30, 16'h0000, 2'h0, "override default");
        wr(8'h2d, 16'hffff, 2'h0);
        rd(8'h2d, 16'h6005, 2'h0, "control mask");
        wr(8'h2e, 16'ha55a, 2'h0);
        wr(8'h2f, 16'hc33c, 2'h0);
        rd(8'h2e, 16'h005a, 2'h0, "inphase trim");
        rd(8'h2f, 16'hc300, 2'h0, "quadrature trim");
        cmp("inphase delay", 32'h5a, {24'h0, inphase_delay});
        cmp("quadrature delay", 32'hc3, {24'h0, quadrature_delay});
        rd(8'h7f, {dtor_id_upper, 5'h0, dtor_device_id, dtor_silicon_rev}, 2'h0, "chip id");
        wr(8'h7f, 16'hffe6, 2'h0);
        rd(8'h7f, {dtor_id_upper, 5'h0, dtor_device_id, dtor_silicon_rev}, 2'h0, "chip id kept");
        wr(8'h31, 16'hffff, 2'h2);
        rd(8'h31, 16'h0000, 2'h2, "unmapped");
    endtask

    task automatic t_strobe();
        for (int s = 0; s < 2; s++) begin
            wr(8'h2d, s ? 16'h4004 : 16'h0004, 2'h0);
            for (int e = 0; e < 2; e++) begin
                external_strobe <= e[0];
                internal_strobe <= ~e[0];
                @(posedge clock);
                cmp("divider strobe", {31'h0, s ? e[0] : ~e[0]}, {31'h0, divider_strobe});
            end
        end
    endtask

    // Transmit enables stay low, yet the override must still drive out
    task automatic t_override();
        wr(8'h30, 16'h1234, 2'h0);
        wr(8'h2d, 16'h0005, 2'h0);
        repeat (3) @(posedge clock);
        cmp("override enable", 32'h1, {31'h0, output_enable});
        cmp("no data clock", 32'h0, {16'h0, inphase_channel});
        for (int f = 0; f < 2; f++) begin
            signed_format <= f[0];
            tick();
            cmp("inphase override", {16'h0, 16'h1234 ^ {f[0], 15'h0}}, {16'h0, inphase_channel});
            cmp("quadrature override", {16'h0, 16'h1234 ^ {f[0], 15'h0}}, {16'h0, quadrature_channel});
        end
        wr(8'h2d, 16'h0004, 2'h0);
        software_tx_enable <= 1'h1;
        repeat (2) @(posedge clock);
        cmp("enable software only", 32'h0, {31'h0, output_enable});
        transmit_enable_pin <= 1'h1;
        repeat (2) @(posedge clock);
        cmp("enable both", 32'h1, {31'h0, output_enable});
    endtask

    // Ramp has never advanced before this point, so it starts from zero
    task automatic t_ramp();
        logic [15:0] prev;
        wr(8'h2d, 16'h2004, 2'h0);
        sample_in <= 16'hbeef;
        tick();
        prev = fifo_entry_data;
        cmp("ramp start", 32'h0, {16'h0, prev});
        tick();
        cmp("ramp step", {16'h0, prev + 16'h1}, {16'h0, fifo_entry_data});
        wr(8'h2d, 16'h0004, 2'h0);
        prev = fifo_entry_data;
        tick();
        cmp("fifo sample", 32'hbeef, {16'h0, fifo_entry_data});
        cmp("channel follows", {16'h0, prev ^ {signed_format, 15'h0}}, {16'h0, inphase_channel});
    endtask

    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'h1;
        repeat (3) @(posedge clock);
        t_words();
        t_fields();
        t_strobe();
        t_override();
        t_ramp();
        results();
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results();
    end
endmodule // dtor_regs_tb
